// ==== rtl/dps_regs.svh ====
// Functional notes
// - short mode: mark sampled first falling edge
// - long mode: mark sampled at sync rise
// - short mode: markers one bit period wide
// - long mode: markers coincide with frame syncs in master mode, trail the sync pins one link cycle in slave
// - driven markers recur every 96 frames
// - d-channel clock rises after link clock rise
// - d-channel data launched on its clock rise
// - d-channel input sampled on its clock fall
// - short/long, 8/10-bit, master or slave modes
// - long mode: syncs sampled on link fall
// - driven syncs rise after link clock rise
// - sync pulse two to eight link cycles
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH

// superframe length in frames
`define DPS_SF_FRAMES     7'h60
`define DPS_SF_LAST       7'h5F
// frame time and link bit rate when this block drives the syncs
`define DPS_FRAME_TIME_US 125
`define DPS_LINK_KHZ      2048
`define DPS_FRAME_BITS    ((`DPS_FRAME_TIME_US * `DPS_LINK_KHZ) / 1000)
// frame sync widths in link bit clocks
`define DPS_FS_W_SHORT    9'h002
`define DPS_FS_W_LONG     9'h008
// d-channel timeslot start bit per format, window length in link clocks
`define DPS_DSLOT_8       9'h010
`define DPS_DSLOT_10      9'h014
`define DPS_DWIN_LEN      9'h004
// d-channel word width and idle level
`define DPS_DWORD_W       2
`define DPS_IDLE          1'h1
// configuration bit positions
`define DPS_CFG_LONG      0
`define DPS_CFG_TEN       1
`define DPS_CFG_MASTER    2
`define DPS_CFG_SFDRV     3
`define DPS_CFG_W         4
// receive buffer depth
`define DPS_BUF_DEPTH     2

`endif

// ==== rtl/dps_pkg.sv ====
`include "dps_regs.svh"

package dps_pkg;

	// one frame's worth of d-channel bits
	typedef logic [`DPS_DWORD_W-1:0] dps_dword_t;
	// frame index inside a superframe
	typedef logic [6:0]              dps_sfidx_t;
	// bit position inside a frame
	typedef logic [8:0]              dps_bitpos_t;
	// synchronised configuration word
	typedef logic [`DPS_CFG_W-1:0]   dps_cfg_t;

endpackage

// ==== rtl/dps_pair_buf.sv ====
`timescale 1ns/1ps

// small in-order queue; head entry drives the outputs straight from flops
module dps_pair_buf #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic [WIDTH-1:0]      out_data_o,
	input  wire logic             out_ready_i
);

	logic [WIDTH-1:0] mem_ff  [DEPTH];   // entries, 0 is head
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [DEPTH-1:0] vld_ff;            // thermometer of used entries
	logic [DEPTH-1:0] nxt_vld;
	logic             push;
	logic             pop;

	////////////////
	// handshakes
	assign in_ready_o  = ~vld_ff[DEPTH-1];   // full only when last is used
	assign out_valid_o = vld_ff[0];
	assign out_data_o  = mem_ff[0];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = vld_ff[0] & out_ready_i;

	////////////////
	// shift down on pop, then write into the first free entry
	always_comb begin
		logic placed;
		placed = 1'h0;
		nxt_vld = vld_ff;
		for (int i = 0; i < DEPTH; i++) begin
			nxt_mem[i] = mem_ff[i];
		end
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				nxt_vld[i] = vld_ff[i+1];
				nxt_mem[i] = mem_ff[i+1];
			end
			nxt_vld[DEPTH-1] = 1'h0;
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (push && !placed && !nxt_vld[i]) begin
				nxt_vld[i] = 1'h1;
				nxt_mem[i] = in_data_i;
				placed = 1'h1;
			end
		end
	end

	// storage update
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			vld_ff <= '0;
		end else begin
			vld_ff <= nxt_vld;
		end
		mem_ff <= nxt_mem;
	end

endmodule

// ==== rtl/dps_superframe_port.sv ====
`timescale 1ns/1ps

// d-channel serial port and superframe markers on the tdm link
module dps_superframe_port
	import dps_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                sys_rst_i,
	input  wire logic                link_bit_clock_i,
	input  wire logic                long_frame_mode_i,
	input  wire logic                ten_bit_format_i,
	input  wire logic                bit_clock_master_i,
	input  wire logic                superframe_drive_i,
	input  wire logic                tx_frame_sync_i,
	output logic                     tx_frame_sync_o,
	output logic                     tx_frame_sync_oe_o,
	input  wire logic                rx_frame_sync_i,
	output logic                     rx_frame_sync_o,
	output logic                     rx_frame_sync_oe_o,
	input  wire logic                tx_superframe_mark_i,
	output logic                     tx_superframe_mark_o,
	output logic                     tx_superframe_mark_oe_o,
	output logic                     rx_superframe_mark_o,
	output logic                     dchan_bit_clock_o,
	output logic                     dchan_serial_out_o,
	input  wire logic                dchan_serial_in_i,
	input  wire logic                dch_tx_valid_i,
	input  wire dps_pkg::dps_dword_t dch_tx_data_i,
	output logic                     dch_tx_ready_o,
	output logic                     dch_rx_valid_o,
	output dps_pkg::dps_dword_t      dch_rx_data_o,
	input  wire logic                dch_rx_ready_i
);

	import dps_pkg::*;

	// next frame index with wrap at the superframe end
	function automatic dps_sfidx_t dps_wrap(input dps_sfidx_t idx);
		dps_wrap = (idx == `DPS_SF_LAST) ? 7'h00 : idx + 7'h01;
	endfunction

	////////////////
	// link domain declarations
	logic        lrst_meta_ff;      // reset crossing, first stage
	logic        lrst_ff;           // reset in the link domain
	dps_cfg_t    cfg_meta_ff;       // config pins, first stage
	dps_cfg_t    cfg_ff;            // config pins, usable
	dps_bitpos_t gen_cnt_ff;        // master frame timer
	logic        tx_fs_ff;          // driven transmit sync
	logic        rx_fs_ff;          // driven receive sync
	logic        fs_oe_ff;          // sync pins driven
	logic        tx_fs_neg_ff;      // transmit sync seen at link fall
	logic        rx_fs_neg_ff;      // receive sync seen at link fall
	logic        sf_smp_ff;         // marker sampled at this frame
	logic        sfx_pos_ff;        // marker at last link rise
	logic        tx_fs_pd_ff;       // transmit sync, one rise later
	logic        rx_fs_pd_ff;       // receive sync, one rise later
	dps_sfidx_t  tx_cnt_ff;         // index of next transmit frame
	dps_sfidx_t  rx_cnt_ff;         // index of next receive frame
	logic        tx_sf_frame_ff;    // current transmit frame is first
	logic        rx_sf_frame_ff;    // current receive frame is first
	logic        tx_mark_ff;        // transmit marker output
	logic        tx_mark_oe_ff;     // transmit marker driven
	logic        rx_mark_ff;        // receive marker output
	dps_bitpos_t bit_cnt_ff;        // bit position since frame start
	logic        dch_clk_ff;        // d-channel clock output
	logic        dout_ff;           // d-channel data output
	logic        rx_bit_ff;         // first received bit of the word
	dps_dword_t  tx_word_ff;        // word being sent this frame
	logic        tx_have_ff;        // a word is waiting to be sent
	logic        tx_req_meta_ff;    // transmit request, first stage
	logic        tx_req_s_ff;       // transmit request, usable
	logic        tx_ack_ff;         // transmit acknowledge toggle
	dps_dword_t  rx_data_ff;        // received word held for crossing
	logic        rx_req_ff;         // receive request toggle
	logic        rx_ack_meta_ff;    // receive acknowledge, first stage
	logic        rx_ack_s_ff;       // receive acknowledge, usable

	// system domain declarations
	logic        tx_ready_ff;       // tx holding free
	dps_dword_t  tx_hold_ff;        // word for link
	logic        tx_req_ff;         // tx request toggle
	logic        tx_ack_meta_ff;    // tx ack, stage 1
	logic        tx_ack_s_ff;       // tx ack, usable
	logic        rx_req_meta_ff;    // rx request, stage 1
	logic        rx_req_s_ff;       // rx request, usable
	logic        rx_ack_ff;         // rx ack toggle

	////////////////
	// decode of modes
	wire is_long   = cfg_ff[`DPS_CFG_LONG];
	wire is_ten    = cfg_ff[`DPS_CFG_TEN];
	wire is_master = cfg_ff[`DPS_CFG_MASTER];
	wire sf_drive  = cfg_ff[`DPS_CFG_SFDRV];

	// master frame timer and generated sync level
	wire dps_bitpos_t frame_last =
		dps_bitpos_t'(`DPS_FRAME_BITS - 1);
	wire dps_bitpos_t fs_width =
		is_long ? `DPS_FS_W_LONG : `DPS_FS_W_SHORT;
	wire dps_bitpos_t nxt_gen_cnt =
		(gen_cnt_ff == frame_last) ? 9'h000 : gen_cnt_ff + 9'h001;
	wire fs_gen_nxt = is_master & (nxt_gen_cnt < fs_width);

	// sync sources: own drive in master mode, pin otherwise
	wire tx_fs_src = is_master ? tx_fs_ff : tx_frame_sync_i;
	wire rx_fs_src = is_master ? rx_fs_ff : rx_frame_sync_i;

	// frame starts as seen at the link rising edge
	wire tx_start = tx_fs_neg_ff & ~tx_fs_pd_ff;
	wire rx_start = rx_fs_neg_ff & ~rx_fs_pd_ff;

	// superframe alignment from a sampled input marker
	wire realign = tx_start & ~sf_drive & sf_smp_ff;
	wire dps_sfidx_t tx_cur = realign ? 7'h00 : tx_cnt_ff;
	wire dps_sfidx_t rx_cur = realign ? 7'h00 : rx_cnt_ff;
	wire tx_first = (tx_cur == 7'h00);
	wire rx_first = (rx_cur == 7'h00);

	// marker levels per mode
	wire tx_lvl = is_master ? fs_gen_nxt : tx_fs_neg_ff;
	wire rx_lvl = is_master ? fs_gen_nxt : rx_fs_neg_ff;
	wire tx_long_mk = tx_lvl & (tx_fs_pd_ff ? tx_sf_frame_ff : tx_first);
	wire rx_long_mk = rx_lvl & (rx_fs_pd_ff ? rx_sf_frame_ff : rx_first);
	wire tx_mark_nxt = is_long ? tx_long_mk : (tx_start & tx_first);
	wire rx_mark_nxt = is_long ? rx_long_mk : (rx_start & rx_first);

	// d-channel timeslot window
	wire dps_bitpos_t cur_bit = tx_start ? 9'h000 : bit_cnt_ff;
	wire dps_bitpos_t dslot = is_ten ? `DPS_DSLOT_10 : `DPS_DSLOT_8;
	wire dps_bitpos_t win_off = cur_bit - dslot;
	wire in_win = (cur_bit >= dslot) && (win_off < `DPS_DWIN_LEN);
	wire [1:0] phase = win_off[1:0];
	wire win_end = in_win & (phase == 2'h3);
	wire tx_bit = tx_have_ff ? tx_word_ff[~phase[1]] : `DPS_IDLE;
	wire tx_load = ~in_win & ~tx_have_ff & (tx_req_s_ff != tx_ack_ff);
	wire rx_free = (rx_req_ff == rx_ack_s_ff);

	////////////////
	// reset and configuration crossings into the link domain
	always_ff @(posedge link_bit_clock_i) begin
		lrst_meta_ff <= sys_rst_i;
		lrst_ff      <= lrst_meta_ff;
	end

	// mode pins, two flops before use
	always_ff @(posedge link_bit_clock_i) begin
		cfg_meta_ff <= {superframe_drive_i, bit_clock_master_i,
			ten_bit_format_i, long_frame_mode_i};
		cfg_ff      <= cfg_meta_ff;
	end

	////////////////
	// master frame sync generation, launched on the link rise
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			gen_cnt_ff <= frame_last;
			tx_fs_ff   <= 1'h0;
			rx_fs_ff   <= 1'h0;
			fs_oe_ff   <= 1'h0;
		end else begin
			gen_cnt_ff <= nxt_gen_cnt;
			tx_fs_ff   <= fs_gen_nxt;
			rx_fs_ff   <= fs_gen_nxt;
			fs_oe_ff   <= is_master;
		end
	end

	////////////////
	// falling-edge sampling of syncs and of the input marker
	always_ff @(negedge link_bit_clock_i) begin
		if (lrst_ff) begin
			tx_fs_neg_ff <= 1'h0;
			rx_fs_neg_ff <= 1'h0;
			sf_smp_ff    <= 1'h0;
		end else begin
			tx_fs_neg_ff <= tx_fs_src;
			rx_fs_neg_ff <= rx_fs_src;
			// first fall with sync high takes the marker
			if (tx_fs_src && !tx_fs_neg_ff) begin
				sf_smp_ff <= is_long ? sfx_pos_ff
					: tx_superframe_mark_i;
			end
		end
	end

	// marker as it stood at the last link rise, the sync's own rise
	always_ff @(posedge link_bit_clock_i) begin
		sfx_pos_ff <= tx_superframe_mark_i;
	end

	////////////////
	// frame starts and modulo-96 frame counters
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			tx_fs_pd_ff <= 1'h0;
			rx_fs_pd_ff <= 1'h0;
			tx_cnt_ff   <= 7'h00;
			rx_cnt_ff   <= 7'h00;
		end else begin
			tx_fs_pd_ff <= tx_fs_neg_ff;
			rx_fs_pd_ff <= rx_fs_neg_ff;
			// transmit count realigns on a sampled marker
			if (tx_start) begin
				tx_cnt_ff <= dps_wrap(tx_cur);
			end
			// receive count follows the same alignment
			if (rx_start) begin
				rx_cnt_ff <= dps_wrap(rx_cur);
			end else if (realign) begin
				rx_cnt_ff <= 7'h00;
			end
		end
	end

	// first-frame flags held for the length of each sync
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			tx_sf_frame_ff <= 1'h0;
			rx_sf_frame_ff <= 1'h0;
		end else begin
			if (tx_start) begin
				tx_sf_frame_ff <= tx_first;
			end
			if (rx_start) begin
				rx_sf_frame_ff <= rx_first;
			end
		end
	end

	////////////////
	// superframe marker outputs
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			tx_mark_ff    <= 1'h0;
			tx_mark_oe_ff <= 1'h0;
			rx_mark_ff    <= 1'h0;
		end else begin
			tx_mark_ff    <= sf_drive & tx_mark_nxt;
			tx_mark_oe_ff <= sf_drive;
			rx_mark_ff    <= rx_mark_nxt;
		end
	end

	////////////////
	// bit position inside the frame, saturating until the next sync
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			bit_cnt_ff <= frame_last;
		end else if (tx_start) begin
			bit_cnt_ff <= 9'h001;
		end else if (bit_cnt_ff != frame_last) begin
			bit_cnt_ff <= bit_cnt_ff + 9'h001;
		end
	end

	// d-channel clock: rises with the link rise at even window steps
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			dch_clk_ff <= 1'h0;
		end else begin
			dch_clk_ff <= in_win & ~phase[0];
		end
	end

	// d-channel output: new bit with each d-channel clock rise
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			dout_ff <= `DPS_IDLE;
		end else if (!in_win) begin
			dout_ff <= `DPS_IDLE;
		end else if (!phase[0]) begin
			dout_ff <= tx_bit;
		end
	end

	// d-channel input: taken as the d-channel clock falls
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			rx_bit_ff <= 1'h0;
		end else if (in_win && phase == 2'h1) begin
			rx_bit_ff <= dchan_serial_in_i;
		end
	end

	////////////////
	// transmit word handshake, link end
	always_ff @(posedge link_bit_clock_i) begin
		tx_req_meta_ff <= tx_req_ff;
		tx_req_s_ff    <= tx_req_meta_ff;
	end

	// word is taken outside the window and spent at its end
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			tx_have_ff <= 1'h0;
			tx_ack_ff  <= 1'h0;
			tx_word_ff <= '0;
		end else if (tx_load) begin
			tx_have_ff <= 1'h1;
			tx_ack_ff  <= ~tx_ack_ff;
			tx_word_ff <= tx_hold_ff;
		end else if (win_end) begin
			tx_have_ff <= 1'h0;
		end
	end

	// receive word handshake, link end; a word is dropped while busy
	always_ff @(posedge link_bit_clock_i) begin
		rx_ack_meta_ff <= rx_ack_ff;
		rx_ack_s_ff    <= rx_ack_meta_ff;
	end

	// completed word is held until the system side answers
	always_ff @(posedge link_bit_clock_i) begin
		if (lrst_ff) begin
			rx_req_ff  <= 1'h0;
			rx_data_ff <= '0;
		end else if (win_end && rx_free) begin
			rx_req_ff  <= ~rx_req_ff;
			rx_data_ff <= {rx_bit_ff, dchan_serial_in_i};
		end
	end

	////////////////
	// transmit word handshake, system end
	always_ff @(posedge clk_i) begin
		tx_ack_meta_ff <= tx_ack_ff;
		tx_ack_s_ff    <= tx_ack_meta_ff;
	end

	// holding register is free again once the link acknowledges
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_ready_ff <= 1'h0;
			tx_req_ff   <= 1'h0;
			tx_hold_ff  <= '0;
		end else if (dch_tx_valid_i && tx_ready_ff) begin
			tx_ready_ff <= 1'h0;
			tx_req_ff   <= ~tx_req_ff;
			tx_hold_ff  <= dch_tx_data_i;
		end else if (!tx_ready_ff && tx_ack_s_ff == tx_req_ff) begin
			tx_ready_ff <= 1'h1;
		end
	end

	// receive word handshake, system end
	always_ff @(posedge clk_i) begin
		rx_req_meta_ff <= rx_req_ff;
		rx_req_s_ff    <= rx_req_meta_ff;
	end

	wire rx_pending = (rx_req_s_ff != rx_ack_ff);
	wire buf_ready;
	wire rx_push = rx_pending & buf_ready;

	// acknowledge only once the buffer has taken the word
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rx_ack_ff <= 1'h0;
		end else if (rx_push) begin
			rx_ack_ff <= ~rx_ack_ff;
		end
	end

	// receive buffer; a stalled reader holds the handshake back
	dps_pair_buf #(
		.WIDTH (`DPS_DWORD_W),
		.DEPTH (`DPS_BUF_DEPTH)
	) u_rx_buf (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (rx_pending),
		.in_data_i   (rx_data_ff),
		.in_ready_o  (buf_ready),
		.out_valid_o (dch_rx_valid_o),
		.out_data_o  (dch_rx_data_o),
		.out_ready_i (dch_rx_ready_i)
	);

	////////////////
	// output wiring, all from flops
	assign tx_frame_sync_o         = tx_fs_ff;
	assign tx_frame_sync_oe_o      = fs_oe_ff;
	assign rx_frame_sync_o         = rx_fs_ff;
	assign rx_frame_sync_oe_o      = fs_oe_ff;
	assign tx_superframe_mark_o    = tx_mark_ff;
	assign tx_superframe_mark_oe_o = tx_mark_oe_ff;
	assign rx_superframe_mark_o    = rx_mark_ff;
	assign dchan_bit_clock_o       = dch_clk_ff;
	assign dchan_serial_out_o      = dout_ff;
	assign dch_tx_ready_o          = tx_ready_ff;

endmodule

// ==== tb/dps_superframe_port_chk.sv ====
`timescale 1ns/1ps

// watches link pins and word handshakes of the d-channel port
module dps_port_chk (
	input  wire logic                clk_i,
	input  wire logic                sys_rst_i,
	input  wire logic                link_bit_clock_i,
	input  wire logic                long_frame_mode_i,
	input  wire logic                bit_clock_master_i,
	input  wire logic                tx_frame_sync_o,
	input  wire logic                rx_frame_sync_o,
	input  wire logic                tx_superframe_mark_o,
	input  wire logic                rx_superframe_mark_o,
	input  wire logic                dchan_bit_clock_o,
	input  wire logic                dchan_serial_out_o,
	input  wire logic                dch_tx_valid_i,
	input  wire logic                dch_tx_ready_o,
	input  wire logic                dch_rx_valid_o,
	input  wire dps_pkg::dps_dword_t dch_rx_data_o,
	input  wire logic                dch_rx_ready_i
);
	import dps_pkg::*;

	////////////////
	// link side
	property p_fs_short;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		bit_clock_master_i && !long_frame_mode_i && $rose(tx_frame_sync_o)
		|-> tx_frame_sync_o [*2] ##1 !tx_frame_sync_o;
	endproperty
	a_fs_short: assert property (p_fs_short)
		else $error("short sync width wrong");
	property p_fs_long;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		bit_clock_master_i && long_frame_mode_i && $rose(rx_frame_sync_o)
		|-> rx_frame_sync_o [*8] ##1 !rx_frame_sync_o;
	endproperty
	a_fs_long: assert property (p_fs_long)
		else $error("long sync width wrong");
	property p_long_tx_mark;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		bit_clock_master_i && long_frame_mode_i && $rose(tx_superframe_mark_o)
		|-> $rose(tx_frame_sync_o);
	endproperty
	a_long_tx_mark: assert property (p_long_tx_mark)
		else $error("tx marker not with tx sync");
	property p_long_rx_mark;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		bit_clock_master_i && long_frame_mode_i && $rose(rx_superframe_mark_o)
		|-> $rose(rx_frame_sync_o) ##1 (rx_superframe_mark_o == rx_frame_sync_o);
	endproperty
	a_long_rx_mark: assert property (p_long_rx_mark)
		else $error("rx marker not with rx sync");
	property p_short_tx_mark;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		!long_frame_mode_i && $rose(tx_superframe_mark_o)
		|=> !tx_superframe_mark_o;
	endproperty
	a_short_tx_mark: assert property (p_short_tx_mark)
		else $error("short tx marker too wide");
	property p_short_rx_mark;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		!long_frame_mode_i && $rose(rx_superframe_mark_o)
		|=> !rx_superframe_mark_o;
	endproperty
	a_short_rx_mark: assert property (p_short_rx_mark)
		else $error("short rx marker too wide");
	property p_dclk_pulse;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		$rose(dchan_bit_clock_o) |=> !dchan_bit_clock_o;
	endproperty
	a_dclk_pulse: assert property (p_dclk_pulse)
		else $error("d-channel clock high too long");
	property p_dout_idle;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		!dchan_bit_clock_o && !$past(dchan_bit_clock_o)
		&& !$past(dchan_bit_clock_o, 2) |-> dchan_serial_out_o;
	endproperty
	a_dout_idle: assert property (p_dout_idle)
		else $error("d-channel output not idle");
	property p_dout_launch;
		@(posedge link_bit_clock_i) disable iff (sys_rst_i)
		$changed(dchan_serial_out_o) |-> $rose(dchan_bit_clock_o)
		|| (!dchan_bit_clock_o && dchan_serial_out_o);
	endproperty
	a_dout_launch: assert property (p_dout_launch)
		else $error("d-channel data changed off clock rise");

	////////////////
	// word side; covers for both sides
	property p_tx_take;
		@(posedge clk_i) disable iff (sys_rst_i)
		dch_tx_valid_i && dch_tx_ready_o |=> !dch_tx_ready_o;
	endproperty
	a_tx_take: assert property (p_tx_take)
		else $error("tx ready held after take");
	property p_rx_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		dch_rx_valid_o && !dch_rx_ready_i
		|=> dch_rx_valid_o && $stable(dch_rx_data_o);
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("rx word lost while stalled");
	c_rx_mark: cover property (@(posedge link_bit_clock_i)
		$rose(rx_superframe_mark_o));
	c_rx_take: cover property (@(posedge clk_i)
		dch_rx_valid_o && dch_rx_ready_i);
	c_long_dclk: cover property (@(posedge link_bit_clock_i)
		long_frame_mode_i && $rose(dchan_bit_clock_o));
endmodule

bind dps_superframe_port dps_port_chk dps_port_chk_i (
	.clk_i, .sys_rst_i, .link_bit_clock_i, .long_frame_mode_i,
	.bit_clock_master_i, .tx_frame_sync_o, .rx_frame_sync_o,
	.tx_superframe_mark_o, .rx_superframe_mark_o, .dchan_bit_clock_o,
	.dchan_serial_out_o, .dch_tx_valid_i, .dch_tx_ready_o,
	.dch_rx_valid_o, .dch_rx_data_o, .dch_rx_ready_i
);

// ==== tb/dps_far_end.sv ====
`timescale 1ns/1ps

// far-end controller: frame syncs, marker, d-channel bits both ways
module dps_far_end (
	input  wire logic       lclk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic       long_i,
	input  wire logic [1:0] word_i,
	input  wire logic       dclk_i,
	input  wire logic       dout_i,
	output logic            fs_o,
	output logic            sfm_o,
	output logic            din_o,
	output logic [1:0]      got_o,
	output logic [7:0]      got_n_o
);
	logic [7:0] pos_ff;  // link bit inside frame
	logic [6:0] frm_ff;  // frame inside superframe
	logic       bit_ff;  // second bit of window next
	logic [7:0] nxt_pos;
	logic [6:0] nxt_frm;
	logic [7:0] fs_w;
	assign nxt_pos = pos_ff + 8'h01;
	assign fs_w    = long_i ? 8'h08 : 8'h02;
	assign nxt_frm = (nxt_pos != 8'hFF) ? frm_ff :
		(frm_ff == 7'h5F) ? 7'h00 : frm_ff + 7'h01;

	// frame timing, first sync comes soon after reset
	always @(posedge lclk_i) begin
		if (rst_i) begin
			pos_ff <= 8'hC8;
			frm_ff <= 7'h5F;
			fs_o   <= 1'h0;
			sfm_o  <= 1'h0;
		end else if (run_i) begin
			pos_ff <= nxt_pos;
			frm_ff <= nxt_frm;
			fs_o   <= nxt_pos < fs_w;
			sfm_o  <= nxt_frm == 7'h00 && (nxt_pos == 8'hFF || nxt_pos < fs_w);
		end
	end

	// launch on d-clock rise, sample on fall, inverse level afterwards
	always @(posedge dclk_i, negedge dclk_i, posedge rst_i) begin
		if (rst_i) begin
			bit_ff  <= 1'h0;
			din_o   <= 1'h0;
			got_n_o <= 8'h00;
		end else if (dclk_i) begin
			din_o  <= bit_ff ? word_i[0] : word_i[1];
			bit_ff <= ~bit_ff;
		end else begin
			got_o <= {got_o[0], dout_i};
			if (!bit_ff) begin
				got_n_o <= got_n_o + 8'h01;
				din_o   <= ~din_o;
			end
		end
	end
endmodule

// ==== tb/test_dps_superframe_port.sv ====
`timescale 1ns/1ps

// scenario bench for the d-channel port and superframe markers
module test_dps_superframe_port;
	import dps_pkg::*;
	logic clk_i = 1'h0, lclk = 1'h0, sys_rst_i = 1'h1;
	logic lng = 1'h0, ten = 1'h0, mst = 1'h0, drv = 1'h0;
	logic tx_valid = 1'h0, rx_ready = 1'h0;
	dps_dword_t tx_data = 2'h0, pword = 2'h0;
	logic tfs_o, tfs_oe, rfs_o, rfs_oe, tsm_o, tsm_oe, rsm_o, dclk, dout;
	logic din, p_fs, p_sfm, tx_ready, rx_valid, probe;
	dps_dword_t rx_data, got;
	logic [7:0] got_n;
	int n_fail = 0, n_compared = 0, sel = 0;
	// pins carry whichever side enables its driver
	wire tfs_pin = tfs_oe ? tfs_o : p_fs;
	wire rfs_pin = rfs_oe ? rfs_o : p_fs;
	wire sfm_pin = tsm_oe ? tsm_o : p_sfm;
	assign probe = sel == 0 ? tfs_o : sel == 1 ? tsm_o : rsm_o;

	always #5 clk_i = ~clk_i;
	initial begin
		#2.7;
		forever #7.5 lclk = ~lclk;
	end

	dps_superframe_port dps_superframe_port_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_bit_clock_i(lclk),
		.long_frame_mode_i(lng), .ten_bit_format_i(ten),
		.bit_clock_master_i(mst), .superframe_drive_i(drv),
		.tx_frame_sync_i(tfs_pin), .tx_frame_sync_o(tfs_o),
		.tx_frame_sync_oe_o(tfs_oe), .rx_frame_sync_i(rfs_pin),
		.rx_frame_sync_o(rfs_o), .rx_frame_sync_oe_o(rfs_oe),
		.tx_superframe_mark_i(sfm_pin), .tx_superframe_mark_o(tsm_o),
		.tx_superframe_mark_oe_o(tsm_oe), .rx_superframe_mark_o(rsm_o),
		.dchan_bit_clock_o(dclk), .dchan_serial_out_o(dout),
		.dchan_serial_in_i(din), .dch_tx_valid_i(tx_valid),
		.dch_tx_data_i(tx_data), .dch_tx_ready_o(tx_ready),
		.dch_rx_valid_o(rx_valid), .dch_rx_data_o(rx_data),
		.dch_rx_ready_i(rx_ready));
	dps_far_end dps_far_end_i (
		.lclk_i(lclk), .rst_i(sys_rst_i), .run_i(!mst), .long_i(lng),
		.word_i(pword), .dclk_i(dclk), .dout_i(dout), .fs_o(p_fs),
		.sfm_o(p_sfm), .din_o(din), .got_o(got), .got_n_o(got_n));

	////////////////
	// compare, timeout and closing tasks
	task automatic chk_bit(input logic a, input logic e);
		n_compared++;
		if (a !== e) begin
			n_fail++;
			$display("ERROR %0t bit got %b exp %b", $time, a, e);
		end
	endtask
	task automatic chk_word(input dps_dword_t a, input dps_dword_t e);
		n_compared++;
		if (a !== e) begin
			n_fail++;
			$display("ERROR %0t word got %h exp %h", $time, a, e);
		end
	endtask
	task automatic chk_cnt(input int a, input int e);
		n_compared++;
		if (a != e) begin
			n_fail++;
			$display("ERROR %0t count got %0d exp %0d", $time, a, e);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic ran_out(input int i, input int n);
		if (i >= n) begin
			n_fail++;
			$display("ERROR %0t wait ran out", $time);
			results();
		end
	endtask
	// link cycles until the probed pin rises
	task automatic wait_rise(input int n, output int i);
		for (i = 0; i < n; i++) begin
			@(negedge lclk);
			if (probe === 1'h1) break;
		end
		ran_out(i, n);
	endtask
	// link cycles the probed pin stays high
	task automatic high_len(output int i);
		for (i = 1; i < 300; i++) begin
			@(negedge lclk);
			if (probe !== 1'h1) break;
		end
	endtask
	// mode pins settle inside reset; reset levels checked before release
	task automatic do_reset(input logic l, t, m, d);
		@(posedge clk_i) #1;
		sys_rst_i = 1'h1;
		{lng, ten, mst, drv} = {l, t, m, d};
		repeat (12) @(posedge clk_i);
		chk_bit(dout, 1'h1);
		chk_bit(dclk, 1'h0);
		chk_bit(rx_valid | tx_ready | rsm_o | tfs_oe, 1'h0);
		#1 sys_rst_i = 1'h0;
	endtask

	////////////////
	// scenarios
	task automatic t_dchan(input logic l, input logic t);
		int i;
		logic [7:0] n0;
		dps_dword_t w;
		w = {t, ~t};
		pword = ~w;
		rx_ready = 1'h0;
		do_reset(l, t, 1'h0, 1'h0);
		tx_valid = 1'h1;
		tx_data = w;
		for (i = 0; i < 50 && tx_ready !== 1'h1; i++) @(negedge clk_i);
		ran_out(i, 50);
		@(posedge clk_i) #1 tx_valid = 1'h0;
		for (i = 0; i < 1200 && got !== w; i++) @(negedge lclk);
		chk_word(got, w);
		n0 = got_n;
		for (i = 0; i < 300 && got_n == n0; i++) @(negedge lclk);
		chk_word(got, 2'h3);
		repeat (2) begin
			@(negedge clk_i);
			chk_bit(rx_valid, 1'h1);
			chk_word(rx_data, ~w);
			@(posedge clk_i) #1 rx_ready = 1'h1;
			@(posedge clk_i) #1 rx_ready = 1'h0;
			repeat (4) @(posedge clk_i);
		end
	endtask
	task automatic t_mark_in(input logic l);
		int i, n;
		sel = 2;
		rx_ready = 1'h1;
		do_reset(l, 1'h0, 1'h0, 1'h0);
		chk_bit(tsm_oe, 1'h0);
		wait_rise(300, i);
		high_len(n);
		chk_cnt(n, l ? 8 : 1);
		n = 0;
		repeat (256) begin
			@(negedge lclk);
			if (probe === 1'h1) n++;
		end
		chk_cnt(n, 0);
	endtask
	task automatic t_master(input logic l);
		int i, n, k;
		sel = 0;
		do_reset(l, 1'h0, 1'h1, 1'h1);
		wait_rise(300, i);
		high_len(n);
		chk_cnt(n, l ? 8 : 2);
		wait_rise(300, i);
		chk_cnt(i + n + 1, 256);
		if (!l) begin
			sel = 1;
			wait_rise(25000, i);
			for (k = 0; k < 200; k++) begin
				sel = 0;
				high_len(n);
				wait_rise(300, i);
				sel = 1;
				// marker trails the sync rise by one link cycle
				@(negedge lclk);
				if (probe === 1'h1) break;
			end
			chk_cnt(k + 1, 96);
		end
	endtask

	initial begin
		for (int m = 0; m < 4; m++) t_dchan(m[1], m[0]);
		t_mark_in(1'h0);
		t_mark_in(1'h1);
		t_master(1'h1);
		t_master(1'h0);
		results();
	end
endmodule
